/* File: timer_cmp_pkg.sv */
package timer_cmp_pkg;
    // Register word offsets inside one timer (byte address bits 4:2)
    localparam logic [2:0] CTRL_ONE_IDX = 3'h0;
    localparam logic [2:0] CTRL_STATUS_IDX = 3'h1;
    localparam logic [2:0] CMP_ONE_IDX = 3'h2;
    localparam logic [2:0] CMP_TWO_IDX = 3'h3;
    localparam logic [2:0] COUNT_IDX = 3'h4;
    // Byte address bit that selects timer b
    localparam int TIMER_SEL_BIT = 5;
    // Control register one fields
    localparam int CMP_IRQ_EN_BIT = 6;
    localparam int EXT_CLK_SEL_BIT = 5;
    localparam int PWM_MODE_BIT = 4;
    localparam int ONE_PULSE_BIT = 3;
    localparam int OUT_LEVEL_TWO_BIT = 1;
    localparam int OUT_LEVEL_ONE_BIT = 0;
    // Control and status register fields
    localparam int CMP_FLAG_BIT = 7;
    localparam int TIMER_HALT_BIT = 6;
    localparam int FLAG_LOCK_BIT = 0;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET = 16'hFFFF;
    localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
    localparam logic [15:0] PWM_SKIP_VALUE = 16'hFFFC;
endpackage

/* File: timer_compare_flag_disable.sv */
`timescale 1ns/1ps
module timer_compare_flag_disable #(
    parameter int NUM_TIMERS = 2
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_TIMERS-1:0] ext_clk_i,
    output logic [NUM_TIMERS-1:0] compare_output_level_o,
    output logic [NUM_TIMERS-1:0] compare_irq_o
);
    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic wr_fire;
    logic [2:0] reg_idx;
    logic [7:0] ctrl_one_q [NUM_TIMERS];
    logic [15:0] first_compare_value_reg_q [NUM_TIMERS];
    logic [15:0] cmp_two_q [NUM_TIMERS];
    logic [15:0] count_q [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] timer_halt_bit_q;
    logic [NUM_TIMERS-1:0] compare_match_flag_q;
    logic [NUM_TIMERS-1:0] lock_q;
    logic [NUM_TIMERS-1:0] skip_q;
    logic [NUM_TIMERS-1:0] eq_prev_q;
    logic [NUM_TIMERS-1:0] ext_prev_q;
    logic [NUM_TIMERS-1:0] out_q;
    logic [NUM_TIMERS-1:0] irq_q;
    logic [NUM_TIMERS-1:0] equal;
    logic [NUM_TIMERS-1:0] wr_timer;
    logic [NUM_TIMERS-1:0] halt_set_now;
    logic [NUM_TIMERS-1:0] flag_clear;

    assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    assign reg_idx = wb_adr_i[4:2];

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    // Bus answer one cycle after request, dropped the cycle after
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
        end
    end

    // Read mux; unmapped words read zero
    always_comb begin
        int t;
        t = int'(wb_adr_i[timer_cmp_pkg::TIMER_SEL_BIT]);
        rdat_d = 32'h0000_0000;
        if (wb_adr_i[7:6] == 2'h0 && t < NUM_TIMERS) begin
            case (reg_idx)
                timer_cmp_pkg::CTRL_ONE_IDX: begin
                    rdat_d[7:0] = ctrl_one_q[t];
                end
                timer_cmp_pkg::CTRL_STATUS_IDX: begin
                    rdat_d[timer_cmp_pkg::CMP_FLAG_BIT] = compare_match_flag_q[t];
                    rdat_d[timer_cmp_pkg::TIMER_HALT_BIT] = timer_halt_bit_q[t];
                    rdat_d[timer_cmp_pkg::FLAG_LOCK_BIT] = lock_q[t];
                end
                timer_cmp_pkg::CMP_ONE_IDX: begin
                    rdat_d[15:0] = first_compare_value_reg_q[t];
                end
                timer_cmp_pkg::CMP_TWO_IDX: begin
                    rdat_d[15:0] = cmp_two_q[t];
                end
                timer_cmp_pkg::COUNT_IDX: begin
                    rdat_d[15:0] = count_q[t];
                end
                default: begin
                    rdat_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdat_q <= 32'h0000_0000;
        end else begin
            rdat_q <= rdat_d;
        end
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;
    assign compare_output_level_o = out_q;
    assign compare_irq_o = irq_q;

    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
        logic tick;
        logic csr_wr;
        logic [7:0] c1;
        assign c1 = ctrl_one_q[t];
        assign wr_timer[t] = wr_fire && wb_adr_i[7:6] == 2'h0
            && int'(wb_adr_i[timer_cmp_pkg::TIMER_SEL_BIT]) == t;
        assign csr_wr = wr_timer[t] && reg_idx == timer_cmp_pkg::CTRL_STATUS_IDX && wb_sel_i[0];
        assign tick = c1[timer_cmp_pkg::EXT_CLK_SEL_BIT] ? (ext_clk_i[t] & ~ext_prev_q[t]) : 1'b1;
        assign equal[t] = ~timer_halt_bit_q[t] && count_q[t] == first_compare_value_reg_q[t];
        assign halt_set_now[t] = csr_wr && wb_dat_i[timer_cmp_pkg::TIMER_HALT_BIT]
            && ~timer_halt_bit_q[t];
        assign flag_clear[t] = csr_wr && wb_dat_i[timer_cmp_pkg::CMP_FLAG_BIT];

        // Configuration registers
        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                ctrl_one_q[t] <= timer_cmp_pkg::CTRL_ONE_RESET;
                cmp_two_q[t] <= timer_cmp_pkg::CMP_RESET;
                timer_halt_bit_q[t] <= 1'b0;
            end else if (wr_timer[t]) begin
                if (reg_idx == timer_cmp_pkg::CTRL_ONE_IDX && wb_sel_i[0]) begin
                    ctrl_one_q[t] <= wb_dat_i[7:0];
                end
                if (csr_wr) begin
                    timer_halt_bit_q[t] <= wb_dat_i[timer_cmp_pkg::TIMER_HALT_BIT];
                end
                if (reg_idx == timer_cmp_pkg::CMP_TWO_IDX) begin
                    if (wb_sel_i[0]) cmp_two_q[t][7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) cmp_two_q[t][15:8] <= wb_dat_i[15:8];
                end
            end
        end

        // First compare value and PWM pulse skip
        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                first_compare_value_reg_q[t] <= timer_cmp_pkg::CMP_RESET;
                skip_q[t] <= 1'b0;
            end else if (wr_timer[t] && reg_idx == timer_cmp_pkg::CMP_ONE_IDX) begin
                if (wb_sel_i[0]) first_compare_value_reg_q[t][7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) first_compare_value_reg_q[t][15:8] <= wb_dat_i[15:8];
                skip_q[t] <= c1[timer_cmp_pkg::PWM_MODE_BIT] && wb_sel_i[1:0] == 2'h3
                    && wb_dat_i[15:0] == timer_cmp_pkg::PWM_SKIP_VALUE;
            end else if (equal[t] && ~eq_prev_q[t]) begin
                skip_q[t] <= 1'b0;
            end
        end

        // Counter
        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                count_q[t] <= timer_cmp_pkg::COUNT_RELOAD;
                ext_prev_q[t] <= 1'b0;
            end else begin
                ext_prev_q[t] <= ext_clk_i[t];
                if (~timer_halt_bit_q[t] && tick) begin
                    if (c1[timer_cmp_pkg::PWM_MODE_BIT] && count_q[t] == cmp_two_q[t]) begin
                        count_q[t] <= timer_cmp_pkg::COUNT_RELOAD;
                    end else begin
                        count_q[t] <= count_q[t] + 16'h0001;
                    end
                end
            end
        end

        // Compare flag with lock; a set beats a clear
        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                compare_match_flag_q[t] <= 1'b0;
                lock_q[t] <= 1'b0;
                eq_prev_q[t] <= 1'b0;
            end else begin
                eq_prev_q[t] <= equal[t];
                if (equal[t]) begin
                    compare_match_flag_q[t] <= 1'b1;
                end else if (flag_clear[t] && ~lock_q[t]) begin
                    compare_match_flag_q[t] <= 1'b0;
                end
                if (equal[t] && halt_set_now[t]) begin
                    lock_q[t] <= 1'b1;
                end else if (~timer_halt_bit_q[t]) begin
                    lock_q[t] <= 1'b0;
                end
            end
        end

        // Output level and interrupt request
        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                out_q[t] <= 1'b0;
                irq_q[t] <= 1'b0;
            end else begin
                irq_q[t] <= compare_match_flag_q[t] & c1[timer_cmp_pkg::CMP_IRQ_EN_BIT];
                if (c1[timer_cmp_pkg::PWM_MODE_BIT] && ~timer_halt_bit_q[t] && tick
                    && count_q[t] == cmp_two_q[t]) begin
                    out_q[t] <= c1[timer_cmp_pkg::OUT_LEVEL_TWO_BIT];
                end else if (equal[t] && ~skip_q[t]) begin
                    out_q[t] <= c1[timer_cmp_pkg::OUT_LEVEL_ONE_BIT];
                end else if (c1[timer_cmp_pkg::ONE_PULSE_BIT] && ~timer_halt_bit_q[t]
                    && count_q[t] == cmp_two_q[t]) begin
                    out_q[t] <= c1[timer_cmp_pkg::OUT_LEVEL_TWO_BIT];
                end
            end
        end

        flag_lock_hold_a: assert property (
            lock_q[t] && timer_halt_bit_q[t] |=> compare_match_flag_q[t])
            else $error("Locked compare flag was cleared while halted");
        lock_on_halt_a: assert property (
            equal[t] && halt_set_now[t] |=> lock_q[t] && timer_halt_bit_q[t])
            else $error("Halt during compare event did not lock the flag");
        irq_follow_a: assert property (
            compare_match_flag_q[t] && c1[timer_cmp_pkg::CMP_IRQ_EN_BIT]
            && $stable(c1) |=> irq_q[t])
            else $error("Compare interrupt missing while flag set and enabled");
        halt_stops_a: assert property (
            timer_halt_bit_q[t] |=> $stable(count_q[t]))
            else $error("Counter moved while halted");
        ctrl_write_a: assert property (
            wr_timer[t] && reg_idx == timer_cmp_pkg::CTRL_ONE_IDX && wb_sel_i[0]
            && wb_dat_i[7:0] == 8'h00 |=> ##1 ~irq_q[t])
            else $error("Zero control write did not stop the interrupt");
        match_sets_a: assert property (
            equal[t] |=> compare_match_flag_q[t])
            else $error("Compare match did not set the flag");
        pwm_skip_a: assert property (
            skip_q[t] && equal[t] && ~eq_prev_q[t] |=> $stable(out_q[t]) && ~skip_q[t])
            else $error("First PWM pulse was not skipped");
        cover_lock_c: cover property (equal[t] && halt_set_now[t]);
        cover_irq_c: cover property (irq_q[t] ##1 flag_clear[t] ##1 ~compare_match_flag_q[t]);
        cover_skip_c: cover property (skip_q[t] ##[1:300] ~skip_q[t]);
    end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [1:0] ext_clk_i = 2'h0;
    logic [1:0] compare_output_level_o;
    logic [1:0] compare_irq_o;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] rv;
    logic [15:0] c, v, old;
    logic [7:0] b;
    logic [3:0] s;

    timer_compare_flag_disable #(.NUM_TIMERS(2)) dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_clk_i(ext_clk_i), .compare_output_level_o(compare_output_level_o),
        .compare_irq_o(compare_irq_o));

    always #20 core_clk_i = ~core_clk_i;

    task automatic close_out();
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Classic single cycle, held until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] a, input logic [3:0] sl,
                       input logic [31:0] d);
        @(posedge core_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= sl;
        wb_dat_i <= d;
        do @(posedge core_clk_i); while (wb_ack_o !== 1'b1);
        rv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, 4'h3, {16'h0, d});
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 4'h3, 32'h0);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task automatic pulse_ext(input int t, input int n);
        repeat (n) begin
            @(posedge core_clk_i);
            ext_clk_i[t] <= 1'b1;
            @(posedge core_clk_i);
            ext_clk_i[t] <= 1'b0;
        end
    endtask

    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
                                          input logic [3:0] sl);
        return {sl[1] ? n[15:8] : o[15:8], sl[0] ? n[7:0] : o[7:0]};
    endfunction

    initial begin
        void'($urandom(37513));
        idle(3);
        reset_i <= 1'b0;
        wr(8'hC4, 16'hFFFF);
        rd(8'hC4);
        chk("unmapped", rv, 32'h0);
        for (int t = 0; t < 2; t++) begin
            b = 8'(t * 32);
            rd(b);
            chk("ctrl_one", rv, 32'h0);
            rd(b + 8'h08);
            chk("cmp_one", rv, 32'hFFFF);
            wr(b, 16'h0021);
            wr(b + 8'h04, 16'h0080);
            rd(b + 8'h04);
            chk("csr_clear", rv, 32'h0);
            rd(b + 8'h10);
            c = rv[15:0];
            pulse_ext(t, 3);
            rd(b + 8'h10);
            chk("ext_count", rv, {16'h0, c + 16'h3});
            c = rv[15:0];
            wr(b + 8'h08, c);
            idle(2);
            chk("out_level", {31'h0, compare_output_level_o[t]}, 32'h1);
            rd(b + 8'h04);
            chk("flag_set", rv, 32'h80);
            wr(b + 8'h04, 16'h0040);
            wr(b + 8'h04, 16'h00C0);
            rd(b + 8'h04);
            chk("flag_locked", rv, 32'hC1);
            pulse_ext(t, 2);
            rd(b + 8'h10);
            chk("halted_count", rv, {16'h0, c});
            wr(b, 16'h0061);
            idle(2);
            chk("irq_stuck", {31'h0, compare_irq_o[t]}, 32'h1);
            wr(b + 8'h04, 16'h00C0);
            idle(2);
            chk("irq_stays", {31'h0, compare_irq_o[t]}, 32'h1);
            wr(b, 16'h0000);
            idle(2);
            chk("irq_off", {31'h0, compare_irq_o[t]}, 32'h0);
            wr(b + 8'h08, c + 16'h0100);
            wr(b + 8'h04, 16'h0000);
            wr(b + 8'h04, 16'h0080);
            rd(b + 8'h04);
            chk("flag_released", rv, 32'h0);
            wr(b, 16'h0060);
            idle(2);
            chk("irq_restart", {31'h0, compare_irq_o[t]}, 32'h0);
            chk("other_irq", {31'h0, compare_irq_o[1-t]}, 32'h0);
            wr(b, 16'h0020);
            wr(b + 8'h04, 16'h0040);
            idle(2);
            chk("irq_safe_stop", {31'h0, compare_irq_o[t]}, 32'h0);
            wr(b + 8'h04, 16'h0000);
            for (int i = 0; i < 6; i++) begin
                v = 16'($urandom);
                s = 4'($urandom_range(0, 3));
                rd(b + 8'h0C);
                old = rv[15:0];
                bus(1'b1, b + 8'h0C, s, {16'h0, v});
                rd(b + 8'h0C);
                chk("cmp_two", rv, {16'h0, merge(old, v, s)});
            end
            wr(b, 16'h0031);
            rd(b + 8'h10);
            c = rv[15:0];
            wr(b + 8'h0C, c + 16'h0010);
            wr(b + 8'h08, 16'hFFFC);
            wr(b, 16'h0011);
            idle(int'(c) + 28);
            chk("pwm_skipped", {31'h0, compare_output_level_o[t]}, 32'h0);
            idle(24);
            chk("pwm_second", {31'h0, compare_output_level_o[t]}, 32'h1);
            wr(b, 16'h0020);
            rd(b + 8'h10);
            wr(b + 8'h0C, rv[15:0]);
            wr(b, 16'h0028);
            idle(2);
            chk("one_pulse_end", {31'h0, compare_output_level_o[t]}, 32'h0);
        end
        close_out();
    end
endmodule
